//--- common/clpd_pkg.sv
// constants and types for the cold load pick-up detector
// Functional notes
// - inputs are three phase rms magnitudes refreshed every 5 ms tick.
// - each phase is compared against every threshold on every tick.
// - entered conditions leave only when crossing back past 97 % of threshold; the low condition leaves once any phase exceeds 100 %.
// - one value per threshold applies to all three phases.
// - exceedance in one, two or three phases triggers pick-up; here the low and high conditions need all three phases and overcurrent any one.
// - low condition needs all phases below low threshold, default 0.20 In.
// - high condition needs all phases above high threshold, default 1.20 In.
// - any phase above overcurrent threshold, default 2.00 In, releases signal at once.
// - thresholds and timers may be changed by setting groups while running.
// - signal asserts after low condition lasts start time, default 10 s; zero immediate.
// - maximum timer runs while active and all currents high; expiry releases.
// - once asserted the signal stays at least the minimum time, default 0.040 s; overcurrent, maximum timer expiry or block release it sooner.
// - block active at pick-up reports blocked, no action; block 5 ms ahead.
`default_nettype none
package clpd_pkg;
  // magnitudes in units of 0.01 x In
  localparam int MAG_W = 13;
  localparam int TIM_W = 19; // 5 ms steps up to 1800 s
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [MAG_W-1:0] LOW_RST = 13'h0014;   // 0.20 In
  localparam logic [MAG_W-1:0] HIGH_RST = 13'h0078;  // 1.20 In
  localparam logic [MAG_W-1:0] OVER_RST = 13'h00C8;  // 2.00 In
  localparam int TICK_MS = 5;
  localparam int SET_MS = 10000;
  localparam int MAX_MS = 30000;
  localparam int MIN_MS = 40;
  localparam logic [TIM_W-1:0] SET_RST = TIM_W'(SET_MS / TICK_MS);
  localparam logic [TIM_W-1:0] MAX_RST = TIM_W'(MAX_MS / TICK_MS);
  localparam logic [TIM_W-1:0] MIN_RST = TIM_W'(MIN_MS / TICK_MS);
  localparam int RESET_PCT = 97;
  localparam int PCT_DIV = 100;
  // register offsets
  localparam logic [ADDR_W-1:0] REG_LOW = 4'h0;
  localparam logic [ADDR_W-1:0] REG_HIGH = 4'h1;
  localparam logic [ADDR_W-1:0] REG_OVER = 4'h2;
  localparam logic [ADDR_W-1:0] REG_TSET = 4'h3;
  localparam logic [ADDR_W-1:0] REG_TMAX = 4'h4;
  localparam logic [ADDR_W-1:0] REG_TMIN = 4'h5;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h6;
  localparam logic [ADDR_W-1:0] REG_ISTAT = 4'h7;
  localparam logic [ADDR_W-1:0] REG_ICLR = 4'h8;
  localparam logic [ADDR_W-1:0] REG_IEN = 4'h9;
  // interrupt bit positions
  localparam int IRQ_ON = 0;
  localparam int IRQ_OFF = 1;
  localparam int IRQ_BLK = 2;
  localparam int IRQ_OVER = 3;
  localparam int IRQ_W = 4;
  typedef enum logic [2:0] {
    CLPD_NORMAL, CLPD_LOW, CLPD_ON, CLPD_BLOCKED
  } clpd_state_t;
endpackage
`default_nettype wire

//--- rtl/clpd_cmp.sv
// one threshold comparator with 97 % hysteresis over three phases
`default_nettype none
module clpd_cmp (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic tick_in,
  // magnitudes and threshold
  input wire logic [clpd_pkg::MAG_W-1:0] mag_a_in,
  input wire logic [clpd_pkg::MAG_W-1:0] mag_b_in,
  input wire logic [clpd_pkg::MAG_W-1:0] mag_c_in,
  input wire logic [clpd_pkg::MAG_W-1:0] thr_in,
  // per-phase above flags
  output logic [2:0] above_out
);
  import clpd_pkg::*;
  logic [MAG_W+6:0] thr_scaled;
  logic [MAG_W+6:0] mag_scaled [3];
  logic [MAG_W-1:0] mag [3];
  assign mag[0] = mag_a_in;
  assign mag[1] = mag_b_in;
  assign mag[2] = mag_c_in;
  // compare ratios in scaled form, no divider needed
  assign thr_scaled = (MAG_W+7)'(thr_in) * (MAG_W+7)'(RESET_PCT);
  for (genvar p = 0; p < 3; p++) begin : g_ph
    assign mag_scaled[p] = (MAG_W+7)'(mag[p]) * (MAG_W+7)'(PCT_DIV);
    always_ff @(posedge clock_in) begin
      if (srst_in) begin
        above_out[p] <= 1'b0;
      end else if (tick_in) begin
        if (above_out[p]) begin
          above_out[p] <= mag_scaled[p] > thr_scaled;
        end else begin
          above_out[p] <= mag[p] > thr_in;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/clpd_top.sv
// cold load pick-up detector with register port and interrupt
`default_nettype none
module clpd_top (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // measurement chain
  input wire logic tick_in,
  input wire logic [clpd_pkg::MAG_W-1:0] mag_a_in,
  input wire logic [clpd_pkg::MAG_W-1:0] mag_b_in,
  input wire logic [clpd_pkg::MAG_W-1:0] mag_c_in,
  input wire logic block_in,
  // register port
  input wire logic [clpd_pkg::ADDR_W-1:0] addr_in,
  input wire logic [clpd_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [clpd_pkg::DATA_W-1:0] rdata_out,
  // results
  output logic cold_load_signal_out,
  output logic blocked_out,
  output logic irq_out
);
  import clpd_pkg::*;
  logic [MAG_W-1:0] thr_low, thr_high, thr_over;
  logic [TIM_W-1:0] t_set, t_max, t_min;
  logic [TIM_W-1:0] cnt_set, cnt_max, cnt_min;
  logic [2:0] low_above, high_above, over_above;
  logic [IRQ_W-1:0] istat, ien, iev, iclr;
  logic tick_d;
  logic low_all, high_all, over_any;
  clpd_state_t state;
  clpd_cmp u_low (.clock_in(clock_in), .srst_in(srst_in), .tick_in(tick_in), .mag_a_in(mag_a_in),
    .mag_b_in(mag_b_in), .mag_c_in(mag_c_in), .thr_in(thr_low), .above_out(low_above));
  clpd_cmp u_high (.clock_in(clock_in), .srst_in(srst_in), .tick_in(tick_in), .mag_a_in(mag_a_in),
    .mag_b_in(mag_b_in), .mag_c_in(mag_c_in), .thr_in(thr_high), .above_out(high_above));
  clpd_cmp u_over (.clock_in(clock_in), .srst_in(srst_in), .tick_in(tick_in), .mag_a_in(mag_a_in),
    .mag_b_in(mag_b_in), .mag_c_in(mag_c_in), .thr_in(thr_over), .above_out(over_above));
  assign low_all = ~|low_above;
  assign high_all = &high_above;
  assign over_any = |over_above;
  // timers run the cycle after the comparators update
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      tick_d <= 1'b0;
    end else begin
      tick_d <= tick_in;
    end
  end
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      thr_low <= LOW_RST;
      thr_high <= HIGH_RST;
      thr_over <= OVER_RST;
      t_set <= SET_RST;
      t_max <= MAX_RST;
      t_min <= MIN_RST;
      ien <= '0;
    end else if (wr_in) begin
      unique case (addr_in)
        REG_LOW: thr_low <= wdata_in[MAG_W-1:0];
        REG_HIGH: thr_high <= wdata_in[MAG_W-1:0];
        REG_OVER: thr_over <= wdata_in[MAG_W-1:0];
        REG_TSET: t_set <= wdata_in[TIM_W-1:0];
        REG_TMAX: t_max <= wdata_in[TIM_W-1:0];
        REG_TMIN: t_min <= wdata_in[TIM_W-1:0];
        REG_IEN: ien <= wdata_in[IRQ_W-1:0];
        default: ;
      endcase
    end
  end
  // main sequence, evaluated once per tick
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      state <= CLPD_NORMAL;
      cnt_set <= '0;
      cnt_max <= '0;
      cnt_min <= '0;
      cold_load_signal_out <= 1'b0;
      blocked_out <= 1'b0;
      iev <= '0;
    end else begin
      iev <= '0;
      if (tick_d) begin
        unique case (state)
          CLPD_NORMAL: begin
            cnt_set <= '0;
            if (low_all) begin
              state <= CLPD_LOW;
            end
          end
          CLPD_LOW: begin
            if (!low_all) begin
              state <= CLPD_NORMAL;
              cnt_set <= '0;
            end else if (cnt_set + TIM_W'(1) >= t_set || t_set == '0) begin
              if (block_in) begin
                state <= CLPD_BLOCKED;
                blocked_out <= 1'b1;
                iev[IRQ_BLK] <= 1'b1;
              end else begin
                state <= CLPD_ON;
                cold_load_signal_out <= 1'b1;
                cnt_max <= '0;
                cnt_min <= '0;
                iev[IRQ_ON] <= 1'b1;
              end
            end else begin
              cnt_set <= cnt_set + TIM_W'(1);
            end
          end
          CLPD_ON: begin
            if (cnt_min != t_min) begin
              cnt_min <= cnt_min + TIM_W'(1);
            end
            if (high_all) begin
              cnt_max <= cnt_max + TIM_W'(1);
            end
            if (over_any) begin
              state <= CLPD_NORMAL;
              cold_load_signal_out <= 1'b0;
              iev[IRQ_OVER] <= 1'b1;
              iev[IRQ_OFF] <= 1'b1;
            end else if (high_all && cnt_max + TIM_W'(1) >= t_max) begin
              state <= CLPD_NORMAL;
              cold_load_signal_out <= 1'b0;
              iev[IRQ_OFF] <= 1'b1;
            // minimum hold, then release when no inrush
            end else if (!high_all && cnt_min + TIM_W'(1) >= t_min) begin
              state <= CLPD_NORMAL;
              cold_load_signal_out <= 1'b0;
              iev[IRQ_OFF] <= 1'b1;
            end
            // block after activation resets the signal
            if (block_in) begin
              state <= CLPD_BLOCKED;
              cold_load_signal_out <= 1'b0;
              blocked_out <= 1'b1;
              iev[IRQ_OFF] <= 1'b1;
              iev[IRQ_BLK] <= 1'b1;
            end
          end
          CLPD_BLOCKED: begin
            // leave once block drops
            if (!block_in) begin
              state <= CLPD_NORMAL;
              blocked_out <= 1'b0;
              cnt_set <= '0;
            end
          end
          default: state <= CLPD_NORMAL;
        endcase
      end
    end
  end
  assign iclr = (wr_in && addr_in == REG_ICLR) ? wdata_in[IRQ_W-1:0] : '0;
  // sticky status, set wins over clear
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      istat <= '0;
    end else begin
      istat <= (istat & ~iclr) | iev;
    end
  end
  // level interrupt from a flop
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(((istat & ~iclr) | iev) & ien);
    end
  end
  // read data one cycle after strobe, zero otherwise
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      rdata_out <= '0;
    end else begin
      rdata_out <= '0;
      if (rd_in) begin
        unique case (addr_in)
          REG_LOW: rdata_out <= DATA_W'(thr_low);
          REG_HIGH: rdata_out <= DATA_W'(thr_high);
          REG_OVER: rdata_out <= DATA_W'(thr_over);
          REG_TSET: rdata_out <= DATA_W'(t_set);
          REG_TMAX: rdata_out <= DATA_W'(t_max);
          REG_TMIN: rdata_out <= DATA_W'(t_min);
          REG_STATE: rdata_out <= DATA_W'({high_all, low_all, over_any, cold_load_signal_out, state});
          REG_ISTAT: rdata_out <= DATA_W'(istat);
          REG_IEN: rdata_out <= DATA_W'(ien);
          default: rdata_out <= '0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- test/clpd_meas.sv
// measurement chain model: periodic tick with three phase magnitudes
`default_nettype none
module clpd_meas #(
  parameter int PERIOD = 20
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // levels the bench wants measured
  input wire logic [clpd_pkg::MAG_W-1:0] lvl_a_in,
  input wire logic [clpd_pkg::MAG_W-1:0] lvl_b_in,
  input wire logic [clpd_pkg::MAG_W-1:0] lvl_c_in,
  // measurement outputs
  output logic tick_out,
  output logic [clpd_pkg::MAG_W-1:0] mag_a_out,
  output logic [clpd_pkg::MAG_W-1:0] mag_b_out,
  output logic [clpd_pkg::MAG_W-1:0] mag_c_out
);
  import clpd_pkg::*;
  int cnt;
  always_ff @(posedge clock_in) begin
    cnt <= (srst_in || cnt == PERIOD - 1) ? 0 : cnt + 1;
    tick_out <= !srst_in && cnt == PERIOD - 1;
  end
  // valid only in the tick cycle; junk elsewhere exposes stale sampling
  assign mag_a_out = tick_out ? lvl_a_in : ~lvl_a_in;
  assign mag_b_out = tick_out ? lvl_b_in : ~lvl_b_in;
  assign mag_c_out = tick_out ? lvl_c_in : ~lvl_c_in;
endmodule
`default_nettype wire

//--- test/clpd_top_chk.sv
// assertion checker for the cold load pick-up detector top
`default_nettype none
module clpd_top_chk (
  // clock and reset
  input wire logic clock_in,
  input wire logic srst_in,
  // measurement chain
  input wire logic tick_in,
  input wire logic [clpd_pkg::MAG_W-1:0] mag_a_in,
  input wire logic [clpd_pkg::MAG_W-1:0] mag_b_in,
  input wire logic [clpd_pkg::MAG_W-1:0] mag_c_in,
  input wire logic block_in,
  // register port
  input wire logic [clpd_pkg::ADDR_W-1:0] addr_in,
  input wire logic [clpd_pkg::DATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [clpd_pkg::DATA_W-1:0] rdata_out,
  // results
  input wire logic cold_load_signal_out,
  input wire logic blocked_out,
  input wire logic irq_out
);
  import clpd_pkg::*;
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  // signal and blocked outputs move only two edges after a tick
  sequence s_tick_back;
    $past(tick_in, 2);
  endsequence
  sequence s_over_tick;
    tick_in && (mag_a_in > OVER_RST || mag_b_in > OVER_RST || mag_c_in > OVER_RST);
  endsequence
  a_on_at_tick: assert property ($rose(cold_load_signal_out) |-> s_tick_back)
    else $error("signal rose away from a tick");
  a_off_at_tick: assert property ($fell(cold_load_signal_out) |-> s_tick_back)
    else $error("signal fell away from a tick");
  a_over_release: assert property (s_over_tick |-> ##2 !cold_load_signal_out)
    else $error("overcurrent did not release signal");
  a_block_entry: assert property ($rose(blocked_out) |-> s_tick_back ##0 $past(block_in))
    else $error("blocked without block at tick");
  a_block_excl: assert property (!(blocked_out && cold_load_signal_out))
    else $error("blocked and active together");
  a_read_idle: assert property (!$past(rd_in) |-> rdata_out == '0)
    else $error("read data outside read slot");
  a_read_hole: assert property (rd_in && addr_in >= 4'hA |=> rdata_out == '0)
    else $error("unmapped read not zero");
  a_irq_mask: assert property (wr_in && addr_in == REG_IEN && wdata_in[3:0] == 4'h0 |-> ##2 !irq_out)
    else $error("irq high with all enables off");
  a_reset_quiet: assert property ($past(srst_in) |-> !cold_load_signal_out && !blocked_out && !irq_out)
    else $error("outputs active after reset");
endmodule
bind clpd_top clpd_top_chk i_chk (.*);
`default_nettype wire

//--- test/test_clpd_top.sv
// self-checking bench for the cold load pick-up detector
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module test_clpd_top;
  timeunit 1ns;
  timeprecision 1ns;
  import clpd_pkg::*;
  logic clock_in = 0, srst_in = 1, wr_in = 0, rd_in = 0, block_in = 0, tick_in;
  logic cold_load_signal_out, blocked_out, irq_out;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0, rdata_out, rv;
  logic [MAG_W-1:0] la = 13'h0064, lb = 13'h0064, lc = 13'h0064, mag_a_in, mag_b_in, mag_c_in;
  logic [MAG_W-1:0] ha[4] = '{13'h0082, 13'h0082, 13'h0076, 13'h0074};
  logic [MAG_W-1:0] hc[4] = '{13'h006E, 13'h0082, 13'h0076, 13'h0074};
  logic hx[4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  int num_errors = 0, check_count = 0;
  // 100 MHz clock
  initial begin
    forever #5 clock_in = ~clock_in;
  end
  clpd_meas #(.PERIOD(20)) i_meas (.clock_in(clock_in), .srst_in(srst_in), .lvl_a_in(la), .lvl_b_in(lb),
    .lvl_c_in(lc), .tick_out(tick_in), .mag_a_out(mag_a_in), .mag_b_out(mag_b_in), .mag_c_out(mag_c_in));
  clpd_top i_dut (.*);
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // strobes move only right after a rising edge; wr and rd end at a falling edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
    @(negedge clock_in);
  endtask
  // read data is taken in the single cycle it stands
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    @(negedge clock_in);
    rv = rdata_out;
  endtask
  // phase levels and block, changed just after a rising edge
  task automatic lvl(input logic [MAG_W-1:0] a, b, c, input logic blk);
    @(posedge clock_in);
    la <= a;
    lb <= b;
    lc <= c;
    block_in <= blk;
  endtask
  // wait n ticks, then let the two-edge evaluation land
  task automatic ticks(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do begin @(negedge clock_in); k++; end while (tick_in !== 1'b1 && k < 50);
      if (k >= 50) begin num_errors++; summarize(); end
    end
    repeat (3) @(posedge clock_in);
    @(negedge clock_in);
  endtask
  initial begin
    repeat (5) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    // setting defaults and an unmapped hole
    rd(REG_LOW); `CHK(rv, 32'h0000_0014)
    rd(REG_HIGH); `CHK(rv, 32'h0000_0078)
    rd(REG_OVER); `CHK(rv, 32'h0000_00C8)
    rd(REG_TSET); `CHK(rv, 32'h0000_07D0)
    rd(REG_TMAX); `CHK(rv, 32'h0000_1770)
    rd(REG_TMIN); `CHK(rv, 32'h0000_0008)
    rd(4'hF); `CHK(rv, 32'h0000_0000)
    $display("defaults done");
    // run-time setting change, then a start on the fourth low tick
    wr(REG_TSET, 32'h0000_0003);
    wr(REG_TMIN, 32'h0000_0064);
    wr(REG_TMAX, 32'h0000_0004);
    wr(REG_IEN, 32'h0000_000F);
    lvl(13'h000A, 13'h000A, 13'h000A, 1'b0);
    ticks(3); `CHK(cold_load_signal_out, 1'b0)
    ticks(1); `CHK(cold_load_signal_out, 1'b1)
    @(negedge clock_in); `CHK(irq_out, 1'b1)
    rd(REG_ISTAT); `CHK(rv[IRQ_ON], 1'b1)
    $display("start timer done");
    // one phase over the top releases at once, then clear and mask
    lvl(13'h000A, 13'h00C9, 13'h000A, 1'b0);
    ticks(1); `CHK(cold_load_signal_out, 1'b0)
    wr(REG_ICLR, 32'h0000_000F);
    wr(REG_IEN, 32'h0000_0000);
    @(negedge clock_in); `CHK(irq_out, 1'b0)
    $display("overcurrent release done");
    // high condition needs all phases and leaves only at 97 %
    foreach (ha[i]) begin
      lvl(ha[i], ha[i], hc[i], 1'b0);
      ticks(1);
      rd(REG_STATE); `CHK(rv[6], hx[i])
    end
    $display("hysteresis done");
    // blocked at pick-up, then released start ended by the maximum timer
    wr(REG_TSET, 32'h0000_0000);
    lvl(13'h000A, 13'h000A, 13'h000A, 1'b1);
    ticks(3); `CHK(blocked_out, 1'b1)
    `CHK(cold_load_signal_out, 1'b0)
    lvl(13'h000A, 13'h000A, 13'h000A, 1'b0);
    ticks(4); `CHK(cold_load_signal_out, 1'b1)
    lvl(13'h0082, 13'h0082, 13'h0082, 1'b0);
    ticks(3); `CHK(cold_load_signal_out, 1'b1)
    ticks(3); `CHK(cold_load_signal_out, 1'b0)
    $display("block and maximum timer done");
    summarize();
  end
endmodule
`default_nettype wire
